// File: core/e1sa_params.svh
`ifndef E1SA_PARAMS_SVH
`define E1SA_PARAMS_SVH

// Register offsets on the parallel control port
`define E1SA_ADDR_SR1 8'h06
`define E1SA_ADDR_SR2 8'h07
`define E1SA_ADDR_SSR 8'h1E
`define E1SA_RST_BYTE 8'h00

// Receive alarm status field positions
`define E1SA_SR1_SA1 7
`define E1SA_SR1_DMA 6
`define E1SA_SR1_SA0 5
`define E1SA_SR1_SLIP 4
`define E1SA_SR1_UA1 3
`define E1SA_SR1_RRA 2
`define E1SA_SR1_RCL 1
`define E1SA_SR1_LOS 0

// Frame event status field positions
`define E1SA_SR2_RMF 7
`define E1SA_SR2_RAF 6
`define E1SA_SR2_TMF 5
`define E1SA_SR2_SEC 4
`define E1SA_SR2_TAF 3
`define E1SA_SR2_TX_CLOCK_LOSS 2
`define E1SA_SR2_RX_CRC4_MF_FLAG 1
`define E1SA_SR2_TX_STORE_SLIP 0

// Stream positions: bit index 0 is the first bit of a timeslot
`define E1SA_TS0 5'h00
`define E1SA_TS16 5'h10
`define E1SA_BIT_FIRST 3'h0
`define E1SA_BIT_LAST 3'h7
`define E1SA_BIT_DMA 3'h5
`define E1SA_BIT_RRA 3'h2
`define E1SA_FRAME_FIRST 4'h0
`define E1SA_FRAME_LAST 4'hF

// Alarm thresholds
`define E1SA_SA_ZEROS 2'h3
`define E1SA_UA_WIN_LAST 9'h1FF
`define E1SA_UA_ZEROS 2'h3
`define E1SA_RCL_ZRUN_LAST 8'hFE
`define E1SA_RCL_ZRUN_MAX 8'hFF
`define E1SA_RCL_WIN_LAST 8'hFE
`define E1SA_RCL_ONES_LAST 6'h1F
`define E1SA_RRA_RUN 2'h3

// Timing, counted in received frames and bits
`define E1SA_FRAME_US 125
`define E1SA_SEC_US 1000000
`define E1SA_FAST_US 62500
`define E1SA_SEC_FRAMES (`E1SA_SEC_US / `E1SA_FRAME_US)
`define E1SA_FAST_FRAMES (`E1SA_FAST_US / `E1SA_FRAME_US)
`define E1SA_CHAN_BITS 8

`endif

// File: core/e1sa_pkg.sv
package e1sa_pkg;
    typedef logic [7:0] e1sa_byte_t;
    // Carrier state, one Gray step between the two
    typedef enum logic {
        E1SA_CL_OK = 1'b0,
        E1SA_CL_LOST = 1'b1
    } e1sa_cl_e;
endpackage

// File: core/e1sa_stream_if.sv
`timescale 1ns/100ps
interface e1sa_stream_if;
    logic ce;
    logic bit_stb;
    logic data;
    logic [4:0] ts;
    logic [2:0] bitn;
    logic [3:0] frame;
    logic sig_ones;
    logic sig_zeros;
    logic unframed_ones;
    logic carrier_loss;
    modport det (
        input ce, bit_stb, data, ts, bitn, frame,
        output sig_ones, sig_zeros, unframed_ones, carrier_loss
    );
    modport core (
        output ce, bit_stb, data, ts, bitn, frame,
        input sig_ones, sig_zeros, unframed_ones, carrier_loss
    );
endinterface

// File: core/e1sa_alarm_det.sv
`timescale 1ns/100ps
`include "e1sa_params.svh"
module e1sa_alarm_det (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Stream and alarms
    e1sa_stream_if.det s
);
    e1sa_pkg::e1sa_cl_e cl_st_ff;
    logic [7:0] zrun_ff;
    logic [7:0] cwin_ff;
    logic [5:0] cones_ff;
    logic [8:0] uwin_ff;
    logic [1:0] uz_ff;
    logic [1:0] sz_ff;
    logic sone_ff;
    logic ua_ff;
    logic sa1_ff;
    logic sa0_ff;
    logic [1:0] nxt_uz;
    logic [1:0] nxt_sz;
    logic sig_bit;
    logic mf_end;

    assign nxt_uz = (!s.data && uz_ff != `E1SA_UA_ZEROS) ? uz_ff + 2'h1 : uz_ff;
    assign nxt_sz = (!s.data && sz_ff != `E1SA_SA_ZEROS) ? sz_ff + 2'h1 : sz_ff;
    assign sig_bit = s.bit_stb && s.ts == `E1SA_TS16;
    assign mf_end = sig_bit && s.frame == `E1SA_FRAME_LAST
        && s.bitn == `E1SA_BIT_LAST;

    // Zero run and one density share one state, so set and clear never race
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cl_st_ff <= e1sa_pkg::E1SA_CL_OK;
            zrun_ff <= 8'h00;
            cwin_ff <= 8'h00;
            cones_ff <= 6'h00;
        end else if (s.ce && s.bit_stb) begin
            zrun_ff <= s.data ? 8'h00 : (zrun_ff == `E1SA_RCL_ZRUN_MAX
                ? zrun_ff : zrun_ff + 8'h01);
            cwin_ff <= (cwin_ff == `E1SA_RCL_WIN_LAST) ? 8'h00
                : cwin_ff + 8'h01;
            cones_ff <= (cwin_ff == `E1SA_RCL_WIN_LAST) ? 6'h00
                : (s.data && cones_ff <= `E1SA_RCL_ONES_LAST)
                ? cones_ff + 6'h01 : cones_ff;
            if (!s.data && zrun_ff == `E1SA_RCL_ZRUN_LAST) begin
                cl_st_ff <= e1sa_pkg::E1SA_CL_LOST;
            end else if (s.data && cones_ff == `E1SA_RCL_ONES_LAST) begin
                cl_st_ff <= e1sa_pkg::E1SA_CL_OK;
            end
        end
    end

    // Unframed all ones over a free 512-bit window
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            uwin_ff <= 9'h000;
            uz_ff <= 2'h0;
            ua_ff <= 1'b0;
        end else if (s.ce && s.bit_stb) begin
            uwin_ff <= uwin_ff + 9'h001;
            if (uwin_ff == `E1SA_UA_WIN_LAST) begin
                uz_ff <= 2'h0;
                ua_ff <= nxt_uz != `E1SA_UA_ZEROS;
            end else begin
                uz_ff <= nxt_uz;
            end
        end
    end

    // Timeslot 16 content judged once per multiframe
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sz_ff <= 2'h0;
            sone_ff <= 1'b0;
            sa1_ff <= 1'b0;
            sa0_ff <= 1'b0;
        end else if (s.ce && sig_bit) begin
            if (mf_end) begin
                sz_ff <= 2'h0;
                sone_ff <= 1'b0;
                sa1_ff <= nxt_sz != `E1SA_SA_ZEROS;
                sa0_ff <= !(sone_ff || s.data);
            end else begin
                sz_ff <= nxt_sz;
                sone_ff <= sone_ff || s.data;
            end
        end
    end

    assign s.sig_ones = sa1_ff;
    assign s.sig_zeros = sa0_ff;
    assign s.unframed_ones = ua_ff;
    assign s.carrier_loss = cl_st_ff == e1sa_pkg::E1SA_CL_LOST;

    rcl_set_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s.ce && s.bit_stb && !s.data && zrun_ff == 8'hFE
        |=> s.carrier_loss)
        else $error("carrier loss not raised after 255 zeros");

    sa0_set_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s.ce && mf_end && !sone_ff && !s.data |=> s.sig_zeros)
        else $error("signaling all zeros not raised");
endmodule

// File: core/e1sa_status_core.sv
`timescale 1ns/100ps
`include "e1sa_params.svh"
module e1sa_status_core (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // Parallel control port
    input wire logic [7:0] cpu_addr_i,
    input wire logic [7:0] cpu_wdata_i,
    input wire logic cpu_wr_i,
    input wire logic cpu_rd_i,
    output logic [7:0] cpu_rdata_o,
    // Control bits held elsewhere
    input wire logic crc4_mode_i,
    input wire logic interval_sel_i,
    input wire logic clock_loss_pin_en_i,
    input wire logic [7:0] interrupt_mask_1_i,
    input wire logic [7:0] interrupt_mask_2_i,
    // Receive stream
    input wire logic rx_bit_stb_i,
    input wire logic rx_positive_data_i,
    input wire logic [4:0] rx_ts_i,
    input wire logic [2:0] rx_bit_i,
    input wire logic [3:0] rx_frame_i,
    input wire logic rx_crc4_mf_stb_i,
    // Synchronizer state
    input wire logic fas_search_active_i,
    input wire logic cas_search_active_i,
    input wire logic crc4_search_active_i,
    input wire logic crc4_sync_ok_i,
    input wire logic crc4_search_expired_i,
    input wire logic rx_sync_loss_i,
    // Elastic stores
    input wire logic rx_store_slip_i,
    input wire logic tx_store_slip_i,
    // Transmit side
    input wire logic tx_frame_stb_i,
    input wire logic [3:0] tx_frame_i,
    input wire logic tx_line_clock_i,
    // Outputs
    output logic int_n_o,
    output logic tx_clock_loss_o
);
    function automatic logic at_slot(input logic [4:0] ts,
        input logic [2:0] b, input logic [4:0] wts, input logic [2:0] wb);
        at_slot = (ts == wts) && (b == wb);
    endfunction

    function automatic e1sa_pkg::e1sa_byte_t sr_addr(input int idx);
        sr_addr = (idx == 0) ? `E1SA_ADDR_SR1 : `E1SA_ADDR_SR2;
    endfunction

    e1sa_stream_if u_if ();

    e1sa_pkg::e1sa_byte_t set_w [2];
    e1sa_pkg::e1sa_byte_t ssr_w;
    logic [5:0] crc4_cnt_ff;
    logic [1:0] dma_hist_ff;
    logic dma_ff;
    logic [1:0] rra_ones_ff;
    logic [1:0] rra_zeros_ff;
    logic rra_ff;
    logic [13:0] tick_cnt_ff;
    logic [13:0] tick_last;
    logic sec_ev;
    logic tx_line_clock_prev_ff;
    logic [3:0] tx_clock_loss_cnt_ff;
    logic tx_clock_loss_ff;
    logic [3:0] free_frame_ff;
    logic rx_fstart;
    logic rmf_ev;
    logic raf_ev;
    logic tmf_ev;
    logic taf_ev;
    logic rx_crc4_mf_flag_ev;
    logic tx_line_clock_edge;
    logic dma_smp;
    logic rra_smp;
    logic [1:0] nxt_rra_ones;
    logic [1:0] nxt_rra_zeros;
    e1sa_pkg::e1sa_byte_t rdata_ff;
    logic int_n_ff;
    logic tx_clock_loss_pin_ff;

    // Stream handed to the alarm detectors
    assign u_if.ce = ce_i;
    assign u_if.bit_stb = rx_bit_stb_i;
    assign u_if.data = rx_positive_data_i;
    assign u_if.ts = rx_ts_i;
    assign u_if.bitn = rx_bit_i;
    assign u_if.frame = rx_frame_i;

    e1sa_alarm_det u_det (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .s(u_if.det)
    );

    // Frame positions
    assign rx_fstart = rx_bit_stb_i
        && at_slot(rx_ts_i, rx_bit_i, `E1SA_TS0, `E1SA_BIT_FIRST);
    assign dma_smp = rx_bit_stb_i && rx_frame_i == `E1SA_FRAME_FIRST
        && at_slot(rx_ts_i, rx_bit_i, `E1SA_TS16, `E1SA_BIT_DMA);
    assign rra_smp = rx_bit_stb_i && rx_frame_i[0]
        && at_slot(rx_ts_i, rx_bit_i, `E1SA_TS0, `E1SA_BIT_RRA);
    assign rmf_ev = rx_fstart && rx_frame_i == `E1SA_FRAME_FIRST;
    assign raf_ev = rx_fstart && !rx_frame_i[0];
    assign tmf_ev = tx_frame_stb_i && tx_frame_i == `E1SA_FRAME_FIRST;
    assign taf_ev = tx_frame_stb_i && !tx_frame_i[0];
    // Without CRC4 the boundary is a free count of received frames
    assign rx_crc4_mf_flag_ev = crc4_mode_i ? rx_crc4_mf_stb_i
        : (rx_fstart && free_frame_ff == `E1SA_FRAME_FIRST);

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            free_frame_ff <= 4'h0;
        end else if (ce_i && rx_fstart) begin
            free_frame_ff <= free_frame_ff + 4'h1;
        end
    end

    // CRC4 search timeout count, wraps on overflow
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            crc4_cnt_ff <= 6'h00;
        end else if (ce_i) begin
            if (!crc4_mode_i || crc4_sync_ok_i) begin
                crc4_cnt_ff <= 6'h00;
            end else if (crc4_search_expired_i) begin
                crc4_cnt_ff <= crc4_cnt_ff + 6'h01;
            end
        end
    end

    // Bit 1 of the count is not brought out
    assign ssr_w = {crc4_cnt_ff[5:2], crc4_cnt_ff[0],
        fas_search_active_i,
        cas_search_active_i,
        crc4_search_active_i};

    // Distant multiframe alarm with two-multiframe hysteresis
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dma_hist_ff <= 2'h0;
            dma_ff <= 1'b0;
        end else if (ce_i && dma_smp) begin
            dma_hist_ff <= {dma_hist_ff[0], rx_positive_data_i};
            if (dma_hist_ff[0] && rx_positive_data_i) begin
                dma_ff <= 1'b1;
            end else if (!dma_hist_ff[0] && !rx_positive_data_i) begin
                dma_ff <= 1'b0;
            end
        end
    end

    // Remote alarm with three-occasion hysteresis
    assign nxt_rra_ones = rx_positive_data_i ? ((rra_ones_ff ==
        `E1SA_RRA_RUN) ? rra_ones_ff : rra_ones_ff + 2'h1) : 2'h0;
    assign nxt_rra_zeros = !rx_positive_data_i ? ((rra_zeros_ff ==
        `E1SA_RRA_RUN) ? rra_zeros_ff : rra_zeros_ff + 2'h1) : 2'h0;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rra_ones_ff <= 2'h0;
            rra_zeros_ff <= 2'h0;
            rra_ff <= 1'b0;
        end else if (ce_i && rra_smp) begin
            rra_ones_ff <= nxt_rra_ones;
            rra_zeros_ff <= nxt_rra_zeros;
            if (nxt_rra_ones == `E1SA_RRA_RUN) begin
                rra_ff <= 1'b1;
            end else if (nxt_rra_zeros == `E1SA_RRA_RUN) begin
                rra_ff <= 1'b0;
            end
        end
    end

    // Timer runs on received frames, so it follows the line, not clk_i
    assign tick_last = interval_sel_i
        ? 14'(`E1SA_FAST_FRAMES - 1) : 14'(`E1SA_SEC_FRAMES - 1);
    assign sec_ev = rx_fstart && tick_cnt_ff >= tick_last;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tick_cnt_ff <= 14'h0000;
        end else if (ce_i && rx_fstart) begin
            tick_cnt_ff <= sec_ev ? 14'h0000 : tick_cnt_ff + 14'h0001;
        end
    end

    // Transmit clock watchdog timed by receive bits
    assign tx_line_clock_edge = tx_line_clock_i != tx_line_clock_prev_ff;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_line_clock_prev_ff <= 1'b0;
            tx_clock_loss_cnt_ff <= 4'h0;
            tx_clock_loss_ff <= 1'b0;
        end else if (ce_i) begin
            tx_line_clock_prev_ff <= tx_line_clock_i;
            if (tx_line_clock_edge) begin
                tx_clock_loss_cnt_ff <= 4'h0;
                tx_clock_loss_ff <= 1'b0;
            end else if (rx_bit_stb_i) begin
                if (tx_clock_loss_cnt_ff == 4'(`E1SA_CHAN_BITS - 1)) begin
                    tx_clock_loss_ff <= 1'b1;
                end else begin
                    tx_clock_loss_cnt_ff <= tx_clock_loss_cnt_ff + 4'h1;
                end
            end
        end
    end

    // Sources for the two latched status registers
    always_comb begin
        set_w[0] = 8'h00;
        set_w[0][`E1SA_SR1_SA1] = u_if.sig_ones;
        set_w[0][`E1SA_SR1_DMA] = dma_ff;
        set_w[0][`E1SA_SR1_SA0] = u_if.sig_zeros;
        set_w[0][`E1SA_SR1_SLIP] = rx_store_slip_i;
        set_w[0][`E1SA_SR1_UA1] = u_if.unframed_ones;
        set_w[0][`E1SA_SR1_RRA] = rra_ff;
        set_w[0][`E1SA_SR1_RCL] = u_if.carrier_loss;
        set_w[0][`E1SA_SR1_LOS] = rx_sync_loss_i;
        set_w[1] = 8'h00;
        set_w[1][`E1SA_SR2_RMF] = rmf_ev;
        set_w[1][`E1SA_SR2_RAF] = raf_ev;
        set_w[1][`E1SA_SR2_TMF] = tmf_ev;
        set_w[1][`E1SA_SR2_SEC] = sec_ev;
        set_w[1][`E1SA_SR2_TAF] = taf_ev;
        set_w[1][`E1SA_SR2_TX_CLOCK_LOSS] = tx_clock_loss_ff;
        set_w[1][`E1SA_SR2_RX_CRC4_MF_FLAG] = rx_crc4_mf_flag_ev;
        set_w[1][`E1SA_SR2_TX_STORE_SLIP] = tx_store_slip_i;
    end

    // Latch and readable copy; a new event wins over a same-cycle clear
    for (genvar g = 0; g < 2; g++) begin : g_sr
        e1sa_pkg::e1sa_byte_t lat_ff;
        e1sa_pkg::e1sa_byte_t copy_ff;
        logic hit;
        assign hit = cpu_wr_i && cpu_addr_i == sr_addr(g);
        always_ff @(posedge clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                lat_ff <= `E1SA_RST_BYTE;
            end else if (ce_i) begin
                if (hit) begin
                    lat_ff <= (lat_ff & ~cpu_wdata_i) | set_w[g];
                end else begin
                    lat_ff <= lat_ff | set_w[g];
                end
            end
        end
        always_ff @(posedge clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                copy_ff <= `E1SA_RST_BYTE;
            end else if (ce_i && hit) begin
                copy_ff <= (copy_ff & ~cpu_wdata_i)
                    | (lat_ff & cpu_wdata_i);
            end
        end
    end

    // Read data is registered and held until the next read
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_ff <= `E1SA_RST_BYTE;
        end else if (ce_i && cpu_rd_i) begin
            if (cpu_addr_i == `E1SA_ADDR_SR1) begin
                rdata_ff <= g_sr[0].copy_ff;
            end else if (cpu_addr_i == `E1SA_ADDR_SR2) begin
                rdata_ff <= g_sr[1].copy_ff;
            end else if (cpu_addr_i == `E1SA_ADDR_SSR) begin
                rdata_ff <= ssr_w;
            end else begin
                rdata_ff <= 8'h00;
            end
        end
    end

    // Interrupt and clock-loss pin
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            int_n_ff <= 1'b1;
            tx_clock_loss_pin_ff <= 1'b0;
        end else if (ce_i) begin
            int_n_ff <= ~|((g_sr[0].lat_ff & interrupt_mask_1_i)
                | (g_sr[1].lat_ff & interrupt_mask_2_i));
            tx_clock_loss_pin_ff <= tx_clock_loss_ff && clock_loss_pin_en_i;
        end
    end

    assign cpu_rdata_o = rdata_ff;
    assign int_n_o = int_n_ff;
    assign tx_clock_loss_o = tx_clock_loss_pin_ff;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    crc_mode_clear_a: assert property (
        ce_i && !crc4_mode_i |=> crc4_cnt_ff == 6'h00)
        else $error("timeout count not cleared with CRC4 off");

    crc_step_a: assert property (
        ce_i && crc4_mode_i && !crc4_sync_ok_i && crc4_search_expired_i
        |=> crc4_cnt_ff == 6'($past(crc4_cnt_ff) + 6'h01))
        else $error("timeout count did not advance by one");

    crc_wrap_a: assert property (
        ce_i && crc4_mode_i && !crc4_sync_ok_i && crc4_search_expired_i
        && crc4_cnt_ff == 6'h3F |=> crc4_cnt_ff == 6'h00)
        else $error("timeout count did not wrap");

    ssr_live_a: assert property (
        ce_i && cpu_rd_i && cpu_addr_i == `E1SA_ADDR_SSR
        |=> cpu_rdata_o == {$past(crc4_cnt_ff[5:2]), $past(crc4_cnt_ff[0]),
        $past(fas_search_active_i), $past(cas_search_active_i),
        $past(crc4_search_active_i)})
        else $error("synchronizer status read wrong");

    latch_hold_a: assert property (
        ce_i && !g_sr[0].hit |=> (g_sr[0].lat_ff & $past(g_sr[0].lat_ff))
        == $past(g_sr[0].lat_ff))
        else $error("latched status bit dropped without a clear");

    mask_copy_a: assert property (
        ce_i && g_sr[1].hit |=> g_sr[1].copy_ff ==
        (($past(g_sr[1].copy_ff) & ~$past(cpu_wdata_i))
        | ($past(g_sr[1].lat_ff) & $past(cpu_wdata_i))))
        else $error("readable copy not updated by mask");

    int_drive_a: assert property (
        ce_i && |(g_sr[0].lat_ff & interrupt_mask_1_i) |=> !int_n_o)
        else $error("unmasked status bit did not interrupt");

    dma_rise_a: assert property (
        $rose(dma_ff) |-> dma_hist_ff == 2'h3)
        else $error("distant multiframe alarm without two ones");

    rra_rise_a: assert property (
        $rose(rra_ff) |-> $past(rra_ones_ff) == 2'h2 && rra_ones_ff == 2'h3)
        else $error("remote alarm without three ones");

    // Pin follows the flag one cycle later; a restarted clock may clear both
    tx_clock_loss_pin_a: assert property (
        ce_i && tx_clock_loss_ff && clock_loss_pin_en_i |=> tx_clock_loss_o)
        else $error("clock-loss pin not driven");

    timer_tick_a: assert property (
        ce_i && sec_ev |=> tick_cnt_ff == 14'h0000
        && g_sr[1].lat_ff[`E1SA_SR2_SEC])
        else $error("timer flag not set on period end");

    rmf_flag_a: assert property (
        ce_i && rmf_ev |=> g_sr[1].lat_ff[`E1SA_SR2_RMF])
        else $error("receive multiframe flag missed");
endmodule

// File: verif/e1sa_line_model.sv
`timescale 1ns/100ps
module e1sa_line_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Control from the bench
    input wire logic level_i,
    input wire logic tx_stop_i,
    // Line side
    output logic stb_o,
    output logic data_o,
    output logic [11:0] pos_o,
    output logic tx_stb_o,
    output logic tx_clk_o
);
    logic ph_ff;
    logic [11:0] pos_ff;
    logic txc_ff;
    // One bit every second cycle; pos is frame, timeslot, bit
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ph_ff <= 1'b0;
            pos_ff <= 12'h000;
        end else begin
            ph_ff <= ~ph_ff;
            if (ph_ff) begin
                pos_ff <= pos_ff + 12'h001;
            end
        end
    end
    // A stopped clock simply freezes, as a dead line would
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            txc_ff <= 1'b0;
        end else if (!tx_stop_i) begin
            txc_ff <= ~txc_ff;
        end
    end
    assign stb_o = ph_ff;
    assign data_o = level_i;
    assign pos_o = pos_ff;
    assign tx_stb_o = ph_ff && pos_ff[7:0] == 8'h00;
    assign tx_clk_o = txc_ff;
endmodule

// File: verif/e1sa_status_core_test.sv
`timescale 1ns/100ps
module e1sa_status_core_test;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, im1 = 8'h00, rdata;
    logic wr = 1'b0, rd = 1'b0, crc_on = 1'b1, ok = 1'b0, expd = 1'b0;
    logic fas = 1'b0, cas = 1'b0, crs = 1'b0, los = 1'b0, lvl = 1'b0;
    logic rsl = 1'b0, tsl = 1'b0, stop = 1'b0, rd_q = 1'b0;
    logic cmf = 1'b0, pen = 1'b1;
    logic [7:0] im2 = 8'h00;
    logic stb, dat, txs, txc, int_n, tx_clock_loss;
    logic [11:0] pos;
    logic [7:0] eq[$], cq[$];
    int errors = 0, total_checks = 0, seed = 32'hD123;
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    e1sa_line_model line (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .level_i(lvl),
        .tx_stop_i(stop), .stb_o(stb), .data_o(dat), .pos_o(pos),
        .tx_stb_o(txs), .tx_clk_o(txc)
    );
    e1sa_status_core dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
        .cpu_addr_i(addr), .cpu_wdata_i(wdata), .cpu_wr_i(wr),
        .cpu_rd_i(rd), .cpu_rdata_o(rdata), .crc4_mode_i(crc_on),
        .interval_sel_i(1'b0), .clock_loss_pin_en_i(pen),
        .interrupt_mask_1_i(im1), .interrupt_mask_2_i(im2),
        .rx_bit_stb_i(stb), .rx_positive_data_i(dat),
        .rx_ts_i(pos[7:3]), .rx_bit_i(pos[2:0]), .rx_frame_i(pos[11:8]),
        .rx_crc4_mf_stb_i(cmf), .fas_search_active_i(fas),
        .cas_search_active_i(cas), .crc4_search_active_i(crs),
        .crc4_sync_ok_i(ok), .crc4_search_expired_i(expd),
        .rx_sync_loss_i(los), .rx_store_slip_i(rsl),
        .tx_store_slip_i(tsl), .tx_frame_stb_i(txs),
        .tx_frame_i(pos[11:8]), .tx_line_clock_i(txc),
        .int_n_o(int_n), .tx_clock_loss_o(tx_clock_loss)
    );
    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cmp8(string n, logic [7:0] e, logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic cmp1(string n, logic e, logic g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %b got %b", n, e, g);
        end
    endtask
    task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
        @(negedge clk_i);
        addr = a;
        wdata = d;
        wr = w;
        rd = !w;
        @(negedge clk_i);
        wr = 1'b0;
        rd = 1'b0;
    endtask
    // Care mask keeps unrelated live bits out of the comparison
    task automatic rdx(logic [7:0] a, logic [7:0] e, logic [7:0] c);
        eq.push_back(e & c);
        cq.push_back(c);
        acc(1'b0, a, 8'h00);
    endtask
    task automatic poll(logic [7:0] a, logic [7:0] m, e, c);
        acc(1'b1, a, m);
        rdx(a, e, c);
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk_i);
        s = 1'b1;
        @(negedge clk_i);
        s = 1'b0;
    endtask
    function automatic logic [7:0] synchronizer_status(logic [5:0] c);
        return {c[5:2], c[0], 3'h0};
    endfunction
    always @(posedge clk_i) rd_q <= rd;
    always @(negedge clk_i) begin
        if (rd_q) cmp8("rdata", eq.pop_front(), rdata & cq.pop_front());
    end
    initial begin
        // About 58k cycles of tests; a hang ends well before 100k cycles
        #1_500_000;
        errors++;
        close_out();
    end
    initial begin
        repeat (8) @(negedge clk_i);
        sys_rst_i = 1'b0;
        repeat (4) begin
            {fas, cas, crs} = 3'($random(seed));
            rdx(8'h1E, {5'h00, fas, cas, crs}, 8'h07);
        end
        for (int k = 1; k <= 65; k++) begin
            pulse(expd);
            if (k == 5 || k == 63 || k == 65)
                rdx(8'h1E, synchronizer_status(6'(k)), 8'hF8);
            // Fifty timeouts make 400 ms, where a host gives up the search
            if (k == 50)
                rdx(8'h1E, synchronizer_status(6'(k)), 8'hF8);
        end
        pulse(ok);
        rdx(8'h1E, 8'h00, 8'hF8);
        // With CRC4 on only the boundary strobe may set the flag
        poll(8'h07, 8'h02, 8'h00, 8'h02);
        pulse(cmf);
        poll(8'h07, 8'h02, 8'h02, 8'h02);
        pulse(expd);
        crc_on = 1'b0;
        rdx(8'h1E, 8'h00, 8'hF8);
        im1 = 8'h10;
        pulse(rsl);
        pulse(tsl);
        cmp1("int_n", 1'b0, int_n);
        poll(8'h06, 8'h10, 8'h10, 8'h10);
        poll(8'h06, 8'h10, 8'h00, 8'h10);
        pulse(rsl);
        poll(8'h06, 8'h00, 8'h00, 8'h10);
        cmp1("int_n", 1'b0, int_n);
        poll(8'h06, 8'h10, 8'h10, 8'h10);
        cmp1("int_n", 1'b1, int_n);
        im2 = 8'h01;
        @(negedge clk_i);
        cmp1("int_n", 1'b0, int_n);
        poll(8'h07, 8'h01, 8'h01, 8'h01);
        cmp1("int_n", 1'b1, int_n);
        // Three multiframes so every multiframe criterion has settled
        los = 1'b1;
        repeat (24576) @(negedge clk_i);
        poll(8'h06, 8'hFF, 8'h00, 8'h00);
        poll(8'h06, 8'hFF, 8'h23, 8'hFF);
        lvl = 1'b1;
        los = 1'b0;
        repeat (24576) @(negedge clk_i);
        poll(8'h06, 8'hFF, 8'h00, 8'h00);
        poll(8'h06, 8'hFF, 8'hCC, 8'hFF);
        poll(8'h07, 8'hEA, 8'h00, 8'h00);
        repeat (8300) @(negedge clk_i);
        poll(8'h07, 8'hEA, 8'hEA, 8'hEA);
        poll(8'h07, 8'hA0, 8'h00, 8'hA0);
        pen = 1'b0;
        stop = 1'b1;
        repeat (40) @(negedge clk_i);
        cmp1("loss_pin", 1'b0, tx_clock_loss);
        pen = 1'b1;
        repeat (2) @(negedge clk_i);
        cmp1("loss_pin", 1'b1, tx_clock_loss);
        poll(8'h07, 8'h04, 8'h04, 8'h04);
        stop = 1'b0;
        repeat (10) @(negedge clk_i);
        cmp1("loss_pin", 1'b0, tx_clock_loss);
        rdx(8'h55, 8'h00, 8'hFF);
        repeat (3) @(negedge clk_i);
        close_out();
    end
endmodule
